// ### rtl/vhc_top.v
// host control of the vbi slicer: line interrupt, mode switch timing, indirect bus,
// fifo read port, word count and the raw/masked event flags with interrupt pin
// assumes the serial host engine, slicer, fifo storage and indirect bus sit on ref_clk
`timescale 1ns/1ps
`include "vhc_map.vh"

module vhc_top (
    input wire ref_clk,
    input wire rst,
    // byte register port from the host engine
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // video timing from the decoder
    input wire line_start,
    input wire [9:0] line_num,
    input wire field_two,
    input wire in_vblank,
    input wire [9:0] pixel_count,
    input wire [7:0] line_mode,
    // slicer mode outputs
    output reg [7:0] slice_mode,
    output reg slice_load,
    // indirect internal bus
    output reg [23:0] ibus_addr,
    output reg [7:0] ibus_wdata,
    output reg ibus_wr,
    output reg ibus_rd,
    input wire [7:0] ibus_rdata,
    // sliced data fifo
    input wire line_offer,
    input wire [7:0] line_words,
    output reg line_accept,
    output reg line_drop,
    input wire [7:0] fifo_rdata,
    output reg fifo_pop,
    output reg video_fifo_en,
    // event sources
    input wire ev_teletext,
    input wire ev_widescreen,
    input wire ev_program_system,
    input wire ev_timecode,
    input wire ev_caption2,
    input wire ev_caption1,
    input wire ev_hv_lock,
    input wire ev_copy_prot,
    input wire ev_standard,
    // interrupt pin
    output reg irq
);

    // decode helper: write or read strobe at one subaddress
    function hit;
        input [7:0] a;
        input [7:0] target;
        input strobe;
        begin
            hit = strobe && (a == target);
        end
    endfunction

    // control registers
    reg [7:0] line_interrupt_control; // field enables and line value
    reg [9:0] slice_switch_pixel_position; // mode switch point after hsync
    reg [7:0] slice_first_line; // start of sliced region
    reg [7:0] slice_last_line; // end of sliced region
    reg [7:0] range_slice_mode; // mode for the whole region
    reg [7:0] whole_field_enable; // bit 0 turns on whole-field slicing
    reg [7:0] whole_field_slice_mode; // mode used in whole-field slicing
    reg [7:0] fifo_output_control; // bit 0 routes fifo to host
    reg [7:0] fifo_threshold; // word count threshold
    reg [7:0] event_mask_low; // mask for low flags
    reg [3:0] event_mask_high; // mask for high flags
    reg [8:0] word_count; // words held in fifo
    reg byte_phase; // high when first byte of a word has been read
    reg line_pending; // a line passed its first line start
    reg lint_fired; // line interrupt already given this field
    reg thr_above_d; // threshold state one cycle ago
    reg inc_after_wr; // autoinc write waiting for its bus strobe

    // decoded strobes
    wire wr_clear_lo;
    wire wr_clear_hi;
    wire acc_fixed_rd;
    wire acc_inc_rd;
    wire acc_fixed_wr;
    wire acc_inc_wr;
    wire fifo_rd;
    wire host_access;
    wire [5:0] lint_value;
    wire lint_field_en;
    wire lint_event;
    wire thr_above;
    wire thr_event;
    wire [9:0] room_words;
    wire line_fits;
    wire [7:0] next_mode;
    wire [11:0] raw;
    wire [11:0] set_pulse;
    wire [11:0] clr_pulse;
    wire [11:0] masked;
    wire [11:0] mask_all;

    assign wr_clear_lo = hit(reg_addr, `VHC_ADR_CLEAR_LO, reg_wr);
    assign wr_clear_hi = hit(reg_addr, `VHC_ADR_CLEAR_HI, reg_wr);
    assign acc_fixed_rd = hit(reg_addr, `VHC_ADR_DATA_FIXED, reg_rd);
    assign acc_inc_rd = hit(reg_addr, `VHC_ADR_DATA_AUTOINC, reg_rd);
    assign acc_fixed_wr = hit(reg_addr, `VHC_ADR_DATA_FIXED, reg_wr);
    assign acc_inc_wr = hit(reg_addr, `VHC_ADR_DATA_AUTOINC, reg_wr);
    assign host_access = fifo_output_control[`VHC_HOST_ACCESS_BIT];
    // host reads pop the fifo only while host access is on
    assign fifo_rd = hit(reg_addr, `VHC_ADR_FIFO_READ, reg_rd) && host_access;

    // line interrupt: first line beyond the value, values 0 and 1 never fire
    assign lint_value = line_interrupt_control[5:0];
    assign lint_field_en = field_two ? line_interrupt_control[`VHC_LINT_F2_BIT]
                                     : line_interrupt_control[`VHC_LINT_F1_BIT];
    assign lint_event = line_start && lint_field_en && !lint_fired
                        && (lint_value >= `VHC_LINE_MIN_VALID)
                        && (line_num > {4'h0, lint_value});

    // threshold flag raised as the word count rises above threshold
    assign thr_above = word_count > {1'b0, fifo_threshold};
    assign thr_event = thr_above && !thr_above_d;

    // room check for a whole line offered by the slicer
    assign room_words = {1'b0, `VHC_FIFO_WORDS} - {1'b0, word_count};
    assign line_fits = {2'b00, line_words} <= room_words;

    // event bits in raw status order, high register above low
    assign set_pulse = {ev_hv_lock, ev_copy_prot, ev_standard, line_offer && !line_fits,
                        thr_event, ev_teletext, ev_widescreen, ev_program_system,
                        ev_timecode, ev_caption2, ev_caption1, lint_event};
    assign clr_pulse = {{4{wr_clear_hi}} & reg_wdata[3:0], {8{wr_clear_lo}} & reg_wdata};
    assign mask_all = {event_mask_high, event_mask_low};
    assign masked = raw & mask_all;

    // sticky raw flags; reads never clear them
    vhc_flags #(
        .N(`VHC_FLAG_COUNT)
    ) u_flags (
        .ref_clk(ref_clk),
        .rst(rst),
        .set_pulse(set_pulse),
        .clr_pulse(clr_pulse),
        .raw(raw)
    );

    // mode of the upcoming line
    vhc_mode_sel u_mode (
        .line_num(line_num),
        .in_vblank(in_vblank),
        .line_mode(line_mode),
        .first_line(slice_first_line),
        .last_line(slice_last_line),
        .range_mode(range_slice_mode),
        .whole_en(whole_field_enable[`VHC_WHOLE_EN_BIT]),
        .whole_mode(whole_field_slice_mode),
        .mode(next_mode)
    );

    // host writes to control registers
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            line_interrupt_control <= `VHC_RST_LINE_INT;
            slice_switch_pixel_position <= `VHC_RST_PIX_POS;
            slice_first_line <= `VHC_RST_FIRST_LINE;
            slice_last_line <= `VHC_RST_LAST_LINE;
            range_slice_mode <= `VHC_RST_MODE;
            whole_field_enable <= 8'h00;
            whole_field_slice_mode <= `VHC_RST_MODE;
            fifo_output_control <= 8'h00;
            fifo_threshold <= `VHC_RST_THRESHOLD;
            event_mask_low <= 8'h00;
            event_mask_high <= 4'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `VHC_ADR_LINE_INT_CTRL: begin
                    line_interrupt_control <= reg_wdata;
                end
                `VHC_ADR_PIX_POS_LO: begin
                    slice_switch_pixel_position[7:0] <= reg_wdata;
                end
                `VHC_ADR_PIX_POS_HI: begin
                    slice_switch_pixel_position[9:8] <= reg_wdata[1:0];
                end
                `VHC_ADR_FIRST_LINE: begin
                    slice_first_line <= reg_wdata;
                end
                `VHC_ADR_LAST_LINE: begin
                    slice_last_line <= reg_wdata;
                end
                `VHC_ADR_RANGE_MODE: begin
                    range_slice_mode <= reg_wdata;
                end
                `VHC_ADR_WHOLE_EN: begin
                    whole_field_enable <= {7'h00, reg_wdata[0]};
                end
                `VHC_ADR_WHOLE_MODE: begin
                    whole_field_slice_mode <= reg_wdata;
                end
                `VHC_ADR_FIFO_OUT_CTRL: begin
                    fifo_output_control <= {7'h00, reg_wdata[0]};
                end
                `VHC_ADR_FIFO_THRESHOLD: begin
                    fifo_threshold <= reg_wdata;
                end
                `VHC_ADR_MASK_LO: begin
                    event_mask_low <= reg_wdata;
                end
                `VHC_ADR_MASK_HI: begin
                    event_mask_high <= reg_wdata[3:0];
                end
                default: begin
                    // other subaddresses hold nothing here
                end
            endcase
        end
    end

    // indirect address: byte writes, auto increment after an autoinc port access
    // reads take their data at once and step at once; a write is shown on the bus
    // one cycle later and steps only then, so it lands at the old address
    // a data-port read right after an autoinc write still sees the old address
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ibus_addr <= 24'h00_0000;
            inc_after_wr <= 1'b0;
        end else begin
            inc_after_wr <= acc_inc_wr;
            if (acc_inc_rd || inc_after_wr) begin
                ibus_addr <= ibus_addr + 24'h00_0001;
            end else if (hit(reg_addr, `VHC_ADR_ADDR_B0, reg_wr)) begin
                ibus_addr[7:0] <= reg_wdata;
            end else if (hit(reg_addr, `VHC_ADR_ADDR_B1, reg_wr)) begin
                ibus_addr[15:8] <= reg_wdata;
            end else if (hit(reg_addr, `VHC_ADR_ADDR_B2, reg_wr)) begin
                ibus_addr[23:16] <= reg_wdata;
            end
        end
    end

    // indirect bus write strobe: one cycle, address shown is the pre-increment one; ibus_rd stays low
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ibus_wr <= 1'b0;
            ibus_rd <= 1'b0;
            ibus_wdata <= 8'h00;
        end else begin
            ibus_wr <= acc_fixed_wr || acc_inc_wr;
            ibus_rd <= 1'b0;
            if (acc_fixed_wr || acc_inc_wr) begin
                ibus_wdata <= reg_wdata;
            end
        end
    end

    // fifo word count: lines push whole word counts, two host reads pop one word
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            word_count <= 9'h000;
            byte_phase <= 1'b0;
            line_accept <= 1'b0;
            line_drop <= 1'b0;
            fifo_pop <= 1'b0;
            thr_above_d <= 1'b0;
        end else begin
            line_accept <= line_offer && line_fits;
            line_drop <= line_offer && !line_fits;
            fifo_pop <= fifo_rd;
            thr_above_d <= thr_above;
            if (fifo_rd) begin
                byte_phase <= !byte_phase;
            end
            if (line_offer && line_fits) begin
                word_count <= word_count + {1'b0, line_words}
                              - {8'h00, fifo_rd && byte_phase && (word_count != 9'h000)};
            end else if (fifo_rd && byte_phase && (word_count != 9'h000)) begin
                word_count <= word_count - 9'h001;
            end
        end
    end

    // line interrupt re-arms at every line start at or below the value
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lint_fired <= 1'b0;
            line_pending <= 1'b0;
        end else if (line_start) begin
            line_pending <= 1'b1;
            if (line_num <= {4'h0, lint_value}) begin
                lint_fired <= 1'b0;
            end else if (lint_event) begin
                lint_fired <= 1'b1;
            end
        end
    end

    // slicer reloads its settings when the pixel count hits the switch point
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slice_mode <= `VHC_MODE_NONE;
            slice_load <= 1'b0;
        end else begin
            slice_load <= 1'b0;
            if (line_pending && (pixel_count == slice_switch_pixel_position)) begin
                slice_mode <= next_mode;
                slice_load <= 1'b1;
            end
        end
    end

    // interrupt pin and fifo routing from flops
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
            video_fifo_en <= 1'b1;
        end else begin
            irq <= |masked;
            video_fifo_en <= !host_access;
        end
    end

    // read data, ready one cycle after the read strobe
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `VHC_ADR_LINE_INT_CTRL: reg_rdata <= line_interrupt_control;
                `VHC_ADR_PIX_POS_LO: reg_rdata <= slice_switch_pixel_position[7:0];
                `VHC_ADR_PIX_POS_HI: reg_rdata <= {6'h00, slice_switch_pixel_position[9:8]};
                `VHC_ADR_FIRST_LINE: reg_rdata <= slice_first_line;
                `VHC_ADR_LAST_LINE: reg_rdata <= slice_last_line;
                `VHC_ADR_RANGE_MODE: reg_rdata <= range_slice_mode;
                `VHC_ADR_WHOLE_EN: reg_rdata <= whole_field_enable;
                `VHC_ADR_WHOLE_MODE: reg_rdata <= whole_field_slice_mode;
                `VHC_ADR_FIFO_OUT_CTRL: reg_rdata <= fifo_output_control;
                `VHC_ADR_FIFO_THRESHOLD: reg_rdata <= fifo_threshold;
                `VHC_ADR_FIFO_WORD_COUNT: reg_rdata <= word_count[8] ? 8'hFF : word_count[7:0];
                `VHC_ADR_DATA_FIXED: reg_rdata <= ibus_rdata;
                `VHC_ADR_DATA_AUTOINC: reg_rdata <= ibus_rdata;
                `VHC_ADR_FIFO_READ: reg_rdata <= host_access ? fifo_rdata : 8'h00;
                `VHC_ADR_ADDR_B0: reg_rdata <= ibus_addr[7:0];
                `VHC_ADR_ADDR_B1: reg_rdata <= ibus_addr[15:8];
                `VHC_ADR_ADDR_B2: reg_rdata <= ibus_addr[23:16];
                `VHC_ADR_RAW_LO: reg_rdata <= raw[7:0];
                `VHC_ADR_RAW_HI: reg_rdata <= {4'h0, raw[11:8]};
                `VHC_ADR_MASKED_LO: reg_rdata <= masked[7:0];
                `VHC_ADR_MASKED_HI: reg_rdata <= {4'h0, masked[11:8]};
                `VHC_ADR_MASK_LO: reg_rdata <= event_mask_low;
                `VHC_ADR_MASK_HI: reg_rdata <= {4'h0, event_mask_high};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

// ### include/vhc_map.vh
// register map, field positions, reset values and sizes of the vbi slicer host control block
// assumes one byte-wide register port on the pixel clock, fed by the serial host port engine
`ifndef VHC_MAP_VH
`define VHC_MAP_VH

// subaddresses
`define VHC_ADR_FIFO_OUT_CTRL 8'hC0
`define VHC_ADR_LINE_INT_CTRL 8'hC1
`define VHC_ADR_PIX_POS_LO 8'hC2
`define VHC_ADR_PIX_POS_HI 8'hC3
`define VHC_ADR_FIFO_THRESHOLD 8'hBD
`define VHC_ADR_FIFO_WORD_COUNT 8'hBC
`define VHC_ADR_FIRST_LINE 8'hD6
`define VHC_ADR_LAST_LINE 8'hD7
`define VHC_ADR_RANGE_MODE 8'hD8
`define VHC_ADR_WHOLE_EN 8'hD9
`define VHC_ADR_WHOLE_MODE 8'hDA
`define VHC_ADR_DATA_FIXED 8'hE0
`define VHC_ADR_DATA_AUTOINC 8'hE1
`define VHC_ADR_FIFO_READ 8'hE2
`define VHC_ADR_ADDR_B0 8'hE8
`define VHC_ADR_ADDR_B1 8'hE9
`define VHC_ADR_ADDR_B2 8'hEA
`define VHC_ADR_RAW_LO 8'hF0
`define VHC_ADR_RAW_HI 8'hF1
`define VHC_ADR_MASKED_LO 8'hF2
`define VHC_ADR_MASKED_HI 8'hF3
`define VHC_ADR_MASK_LO 8'hF4
`define VHC_ADR_MASK_HI 8'hF5
`define VHC_ADR_CLEAR_LO 8'hF6
`define VHC_ADR_CLEAR_HI 8'hF7

// field positions
`define VHC_LINT_F1_BIT 7
`define VHC_LINT_F2_BIT 6
`define VHC_HOST_ACCESS_BIT 0
`define VHC_WHOLE_EN_BIT 0
`define VHC_FLAG_COUNT 12

// reset values
`define VHC_RST_LINE_INT 8'h00
`define VHC_RST_PIX_POS 10'h01E
`define VHC_RST_FIRST_LINE 8'h06
`define VHC_RST_LAST_LINE 8'h1B
`define VHC_RST_MODE 8'hFF
`define VHC_RST_THRESHOLD 8'h80
`define VHC_MODE_NONE 8'hFF
`define VHC_LINE_MIN_VALID 6'h02

// fifo capacity in two-byte words
`define VHC_FIFO_WORDS 9'h100

`endif

// ### rtl/vhc_flags.v
// sticky event flag bank: hardware sets, host clears by writing ones
// assumes set and clear pulses come from logic on the same pixel clock
`timescale 1ns/1ps

module vhc_flags #(
    parameter N = 12
) (
    input wire ref_clk,
    input wire rst,
    input wire [N-1:0] set_pulse,
    input wire [N-1:0] clr_pulse,
    output wire [N-1:0] raw
);

    reg [N-1:0] flag; // one sticky bit per event source
    genvar i;

    // each bit holds until cleared; a set in the clear cycle wins
    generate
        for (i = 0; i < N; i = i + 1) begin : g_flag
            always @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    flag[i] <= 1'b0;
                end else if (set_pulse[i]) begin
                    flag[i] <= 1'b1;
                end else if (clr_pulse[i]) begin
                    flag[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign raw = flag;

endmodule

// ### rtl/vhc_mode_sel.v
// picks the slicing mode of one line from per-line, range and whole-field settings
// assumes all inputs are settled flops of the pixel clock domain
`timescale 1ns/1ps
`include "vhc_map.vh"

module vhc_mode_sel (
    input wire [9:0] line_num,
    input wire in_vblank,
    input wire [7:0] line_mode,
    input wire [7:0] first_line,
    input wire [7:0] last_line,
    input wire [7:0] range_mode,
    input wire whole_en,
    input wire [7:0] whole_mode,
    output reg [7:0] mode
);

    reg in_range; // line inside the programmed region

    // priority: per-line, then range, then whole-field
    always @* begin
        in_range = (line_num >= {2'b00, first_line}) && (line_num <= {2'b00, last_line});
        mode = `VHC_MODE_NONE;
        if (in_range && in_vblank) begin
            if (line_mode != `VHC_MODE_NONE) begin
                mode = line_mode;
            end else if (range_mode != `VHC_MODE_NONE) begin
                mode = range_mode;
            end else if (whole_en) begin
                mode = whole_mode;
            end
        end else if (whole_en && !in_vblank) begin
            mode = whole_mode;
        end
    end

endmodule

// ### bench/vhc_props.sv
// checker for vhc_top: indirect bus address, fifo pop, routing and the interrupt pin
// assumes it is bound to vhc_top and sees its ports only
`timescale 1ns/1ps
module vhc_props (
    input wire ref_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [23:0] ibus_addr,
    input wire [7:0] ibus_wdata,
    input wire ibus_wr,
    input wire fifo_pop,
    input wire video_fifo_en,
    input wire irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // a host access of any kind at one subaddress
    sequence s_acc(a);
        (reg_rd || reg_wr) && reg_addr == a;
    endsequence
    // a host write at one subaddress
    sequence s_wr(a);
        reg_wr && reg_addr == a;
    endsequence
    chk_autoinc_step: assert property (reg_rd && reg_addr == 8'he1 |=>
        ibus_addr == $past(ibus_addr) + 24'h00_0001)
        else $error("indirect address did not advance by one");
    chk_autoinc_wr: assert property (s_wr(8'he1) |=>
        ibus_wr && $stable(ibus_addr) ##1 ibus_addr == $past(ibus_addr) + 24'h00_0001)
        else $error("autoinc write did not step the address after its strobe");
    chk_fixed_keep: assert property (s_acc(8'he0) |=> $stable(ibus_addr))
        else $error("fixed data port moved the address");
    chk_fixed_write: assert property (s_wr(8'he0) |=> ibus_wr && ibus_wdata == $past(reg_wdata))
        else $error("fixed data write not passed on");
    chk_addr_low: assert property (s_wr(8'he8) |=> ibus_addr[7:0] == $past(reg_wdata))
        else $error("address low byte not loaded");
    chk_addr_top: assert property (s_wr(8'hea) |=> ibus_addr[23:16] == $past(reg_wdata))
        else $error("address top byte not loaded");
    chk_pop_cause: assert property (fifo_pop |-> $past(reg_rd && reg_addr == 8'he2 && !video_fifo_en))
        else $error("fifo pop without a host fifo read");
    chk_pop_route: assert property (reg_rd && reg_addr == 8'he2 |=> fifo_pop == !$past(video_fifo_en))
        else $error("fifo read pop does not follow host access");
    chk_route_ctrl: assert property (s_wr(8'hc0) |=> ##1 video_fifo_en == !$past(reg_wdata[0], 2))
        else $error("fifo routing does not follow control bit");
    chk_irq_sticky: assert property (irq && !reg_wr && !$past(reg_wr) |=> irq)
        else $error("interrupt dropped without a host write");
endmodule
bind vhc_top vhc_props i_props (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .ibus_addr(ibus_addr), .ibus_wdata(ibus_wdata), .ibus_wr(ibus_wr),
    .fifo_pop(fifo_pop), .video_fifo_en(video_fifo_en), .irq(irq));

// ### bench/vhc_host_model.sv
// host side of the byte register port: one write or read strobe per call
// assumes the bench owns the clock and judges read data itself
`timescale 1ns/1ps
module vhc_host_model (
    input wire ref_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    // idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // write strobe held to the taking edge, then released with junk data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // read strobe held to the taking edge
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
endmodule

// ### bench/tb_vbi_host_control_and_interrupts.sv
// bench for vhc_top: host model on the register port, video and event stimulus
// assumes vhc_props is bound and vhc_host_model drives the register port
`timescale 1ns/1ps
module tb_vbi_host_control_and_interrupts;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, slice_mode, ibus_wdata, v;
    logic [7:0] line_mode = 8'hff, ibus_rdata = 8'h00, fifo_rdata = 8'h00, line_words = 8'h00;
    logic [9:0] line_num = 10'h000, pixel_count = 10'h000;
    logic [23:0] ibus_addr;
    logic reg_wr, reg_rd, slice_load, ibus_wr, ibus_rd, line_accept, line_drop, fifo_pop, video_fifo_en, irq;
    logic line_start = 1'b0, field_two = 1'b0, in_vblank = 1'b0, line_offer = 1'b0, rd_d = 1'b0;
    logic [8:0] ev = 9'h000;
    wire ev_teletext, ev_widescreen, ev_program_system, ev_timecode, ev_caption2, ev_caption1;
    wire ev_hv_lock, ev_copy_prot, ev_standard;
    int failures = 0;
    int checked = 0;
    logic [7:0] exp_q[$];
    logic [7:0] ra [12] = '{8'hc1, 8'hc2, 8'hc3, 8'hd6, 8'hd7, 8'hd8, 8'hd9, 8'hda, 8'he8, 8'he9, 8'hea, 8'hf4};
    logic [7:0] re [12] = '{8'h00, 8'h1e, 8'h00, 8'h06, 8'h1b, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    assign {ev_teletext, ev_widescreen, ev_program_system, ev_timecode, ev_caption2, ev_caption1,
        ev_hv_lock, ev_copy_prot, ev_standard} = ev;
    vhc_top i_dut (.*);
    vhc_host_model i_host (.*);
    // pixel clock
    always #25 ref_clk = ~ref_clk;
    // watcher: read data lands one edge after the strobe
    always @(posedge ref_clk) begin
        if (rd_d) check(reg_rdata, exp_q.pop_front());
        rd_d <= reg_rd;
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        checked++;
        if (seen !== want) begin
            failures++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.rd(a);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.wr(a, d);
    endtask
    // one-cycle pulse on the event sources
    task automatic pulse(input logic [8:0] p);
        @(posedge ref_clk);
        ev <= p;
        @(posedge ref_clk);
        ev <= 9'h000;
    endtask
    // new line start with its number
    task automatic line(input logic [9:0] n);
        @(posedge ref_clk);
        line_num <= n;
        line_start <= 1'b1;
        @(posedge ref_clk);
        line_start <= 1'b0;
    endtask
    // line start then the switch pixel, returning the loaded mode check
    task automatic mode(input logic [9:0] n, input logic [7:0] lm, input logic vb, input logic [7:0] e);
        line_mode <= lm;
        in_vblank <= vb;
        line(n);
        pixel_count <= 10'h01e;
        @(posedge ref_clk);
        pixel_count <= 10'h000;
        @(posedge ref_clk);
        check(slice_load, 1'b1);
        @(posedge ref_clk);
        check(slice_mode, e);
    endtask
    // sliced line offered to the fifo
    task automatic offer(input logic [7:0] n, input logic fit);
        @(posedge ref_clk);
        line_offer <= 1'b1;
        line_words <= n;
        @(posedge ref_clk);
        line_offer <= 1'b0;
        @(posedge ref_clk);
        check(line_accept, fit);
        check(line_drop, !fit);
    endtask
    task automatic final_report;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog well beyond the couple of hundred cycles the tests need
    initial begin
        #2000000;
        failures++;
        final_report();
    end
    // main sequence
    initial begin
        void'($urandom(32'hae68011f));
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 12; i++) rd(ra[i], re[i]);
        $display("test reset values done");
        wr(8'he8, 8'hfe);
        wr(8'he9, 8'hff);
        wr(8'hea, 8'h00);
        v = $urandom;
        ibus_rdata <= v;
        rd(8'he1, v);
        rd(8'he1, v);
        @(posedge ref_clk);
        check(ibus_addr, 24'h01_0000);
        rd(8'he0, v);
        wr(8'he0, 8'h5a);
        check(ibus_addr, 24'h01_0000);
        wr(8'he1, 8'h3c);
        repeat (2) @(posedge ref_clk);
        check(ibus_addr, 24'h01_0001);
        check(ibus_wdata, 8'h3c);
        $display("test indirect bus done");
        wr(8'hc2, 8'h1e);
        wr(8'hd6, 8'h06);
        mode(10'h00a, 8'h03, 1'b1, 8'h03);
        wr(8'hd8, 8'h05);
        mode(10'h00a, 8'hff, 1'b1, 8'h05);
        wr(8'hd9, 8'h01);
        wr(8'hda, 8'h07);
        mode(10'h100, 8'hff, 1'b0, 8'h07);
        $display("test slice mode done");
        wr(8'hf4, 8'h40);
        pulse(9'h100);
        rd(8'hf0, 8'h40);
        rd(8'hf2, 8'h40);
        check(irq, 1'b1);
        rd(8'hf0, 8'h40);
        wr(8'hf4, 8'h00);
        rd(8'hf2, 8'h00);
        check(irq, 1'b0);
        rd(8'hf0, 8'h40);
        wr(8'hf6, 8'h40);
        rd(8'hf0, 8'h00);
        pulse(9'h1ff);
        rd(8'hf0, 8'h7e);
        rd(8'hf1, 8'h0e);
        wr(8'hf6, 8'hff);
        wr(8'hf7, 8'h0f);
        rd(8'hf1, 8'h00);
        $display("test event flags done");
        wr(8'hf4, 8'h01);
        wr(8'hc1, 8'h85);
        line(10'h005);
        rd(8'hf0, 8'h00);
        line(10'h006);
        rd(8'hf0, 8'h01);
        check(irq, 1'b1);
        wr(8'hf6, 8'h01);
        wr(8'hc1, 8'h45);
        line(10'h003);
        line(10'h006);
        rd(8'hf0, 8'h00);
        field_two <= 1'b1;
        line(10'h003);
        line(10'h006);
        rd(8'hf0, 8'h01);
        wr(8'hf6, 8'h01);
        field_two <= 1'b0;
        wr(8'hc1, 8'hc1);
        line(10'h001);
        line(10'h028);
        rd(8'hf0, 8'h00);
        wr(8'hf4, 8'h00);
        $display("test line interrupt done");
        offer(8'hc8, 1'b1);
        offer(8'h64, 1'b0);
        offer(8'h32, 1'b1);
        rd(8'hbc, 8'hfa);
        rd(8'hf1, 8'h01);
        rd(8'hf0, 8'h80);
        rd(8'he2, 8'h00);
        wr(8'hc0, 8'h01);
        v = $urandom;
        fifo_rdata <= v;
        rd(8'he2, v);
        rd(8'he2, v);
        rd(8'hbc, 8'hf9);
        $display("test fifo done");
        repeat (4) @(posedge ref_clk);
        final_report();
    end
endmodule
